// File: scr_core.sv
// serial register core: spi slave with configuration registers
// Summary of operation
// - soft reset bit resets all registers
// - soft reset bit clears itself
// - ascend bit picks stream direction, resets one
// - output indicator reads one; reads on sdo
// - mode zero normal, three power down
// - maker code fixed and read only
// - freeze bit holds stream address fixed
// - delay select and zoom drive sync delay
`timescale 1ns/1ps
module scr_core #(
  parameter logic [15:0] MAKER_CODE = 16'h00a5 // arbitrary value
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic chip_reset_o,
  output logic power_down_o,
  output logic [1:0] op_mode_o,
  output scr_pkg::scr_sync_ctrl_t sync_ctrl_o
);
  typedef enum logic [1:0] {
    SCR_ST_IDLE = 2'b00,
    SCR_ST_CMD = 2'b01,
    SCR_ST_DATA = 2'b10,
    SCR_ST_QUIET = 2'b11
  } scr_state_t;

  scr_state_t state;
  logic [7:0] setup_reg;
  logic [7:0] mode_reg;
  logic [7:0] user_reg;
  logic [7:0] sync_reg;
  logic [15:0] cmd;
  logic [14:0] addr;
  logic rd_wr;
  logic sclk_d;
  logic cmd_byte;
  logic [9:0] quiet_cnt;
  logic soft_rst;
  logic sample;
  logic shift;
  logic load;
  logic clr;
  logic [7:0] rx_byte;
  logic [7:0] rx_full;
  logic [2:0] bit_cnt;
  logic byte_done;
  logic sdo_bit;
  logic wr_en;

  function automatic logic [7:0] read_reg(input logic [14:0] a, input logic [7:0] su,
                                          input logic [7:0] md, input logic [7:0] us,
                                          input logic [7:0] sy);
    case (a)
      scr_pkg::ADDR_SETUP: read_reg = su | scr_pkg::SETUP_RO_MASK;
      scr_pkg::ADDR_MODE: read_reg = md;
      scr_pkg::ADDR_MAKER_HI: read_reg = MAKER_CODE[15:8];
      scr_pkg::ADDR_MAKER_LO: read_reg = MAKER_CODE[7:0];
      scr_pkg::ADDR_USER: read_reg = us;
      scr_pkg::ADDR_SYNC: read_reg = sy;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  function automatic logic [14:0] step_addr(input logic [14:0] a, input logic asc,
                                            input logic frz);
    if (frz)
      step_addr = a;
    else if (asc)
      step_addr = a + 15'h0001;
    else
      step_addr = a - 15'h0001;
  endfunction : step_addr

  // spi mode 0: sample on rising sclk, shift on falling
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sclk_d <= 1'b0;
    else
      sclk_d <= sclk_i;
  end

  assign sample = !cs_n_i && sclk_i && !sclk_d && (state != SCR_ST_QUIET);
  assign shift = !cs_n_i && !sclk_i && sclk_d && (state == SCR_ST_DATA) && rd_wr
                 && (bit_cnt != 3'h0);
  assign clr = cs_n_i || (state == SCR_ST_QUIET);
  assign wr_en = byte_done && (state == SCR_ST_DATA) && !rd_wr;
  // whole byte, eighth bit taken straight from the pin
  assign rx_full = {rx_byte[6:0], sdi_i};
  assign soft_rst = wr_en && (addr == scr_pkg::ADDR_SETUP)
                    && rx_full[scr_pkg::BIT_SOFT_RESET];

  scr_shift u_shift (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .clr_i(clr),
    .sample_i(sample),
    .shift_i(shift),
    .load_i(load),
    .load_data_i(read_reg(byte_done && state == SCR_ST_CMD ? {cmd[6:0], rx_full}
                          : step_addr(addr, setup_reg[scr_pkg::BIT_ASCEND],
                                      user_reg[scr_pkg::BIT_ADDR_FREEZE]),
                          setup_reg, mode_reg, user_reg, sync_reg)),
    .sdi_i(sdi_i),
    .rx_byte_o(rx_byte),
    .bit_cnt_o(bit_cnt),
    .byte_done_o(byte_done),
    .sdo_bit_o(sdo_bit)
  );

  assign load = byte_done && ((state == SCR_ST_CMD && cmd_byte) || state == SCR_ST_DATA);

  // transaction sequencer
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= SCR_ST_IDLE;
      cmd <= 16'h0000;
      cmd_byte <= 1'b0;
      quiet_cnt <= 10'h000;
    end
    else
    begin
      case (state)
        SCR_ST_IDLE:
        begin
          cmd_byte <= 1'b0;
          if (!cs_n_i)
            state <= SCR_ST_CMD;
        end
        SCR_ST_CMD:
        begin
          if (cs_n_i)
            state <= SCR_ST_IDLE;
          else if (byte_done)
          begin
            cmd <= {cmd[7:0], rx_full};
            cmd_byte <= 1'b1;
            if (cmd_byte)
              state <= SCR_ST_DATA;
          end
        end
        SCR_ST_DATA:
        begin
          if (soft_rst)
          begin
            state <= SCR_ST_QUIET;
            quiet_cnt <= 10'(scr_pkg::QUIET_CYCLES);
          end
          else if (cs_n_i)
            state <= SCR_ST_IDLE;
        end
        SCR_ST_QUIET:
        begin
          if (quiet_cnt != 10'h000)
            quiet_cnt <= quiet_cnt - 10'h001;
          else if (cs_n_i)
            state <= SCR_ST_IDLE;
        end
        default: state <= SCR_ST_IDLE;
      endcase
    end
  end

  // address pointer
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      addr <= 15'h0000;
      rd_wr <= 1'b0;
    end
    else if (state == SCR_ST_CMD && byte_done && cmd_byte)
    begin
      addr <= {cmd[6:0], rx_full};
      rd_wr <= cmd[7];
    end
    else if (state == SCR_ST_DATA && byte_done)
      addr <= step_addr(addr, setup_reg[scr_pkg::BIT_ASCEND],
                        user_reg[scr_pkg::BIT_ADDR_FREEZE]);
  end

  // register writes; soft reset restores every register
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      setup_reg <= scr_pkg::RST_SETUP;
      mode_reg <= scr_pkg::RST_MODE;
      user_reg <= scr_pkg::RST_USER;
      sync_reg <= scr_pkg::RST_SYNC;
    end
    else if (soft_rst)
    begin
      setup_reg <= scr_pkg::RST_SETUP;
      mode_reg <= scr_pkg::RST_MODE;
      user_reg <= scr_pkg::RST_USER;
      sync_reg <= scr_pkg::RST_SYNC;
    end
    else if (wr_en)
    begin
      case (addr)
        scr_pkg::ADDR_SETUP: setup_reg <= {1'b0, rx_full[6:5], 1'b1, rx_full[3:0]};
        scr_pkg::ADDR_MODE: mode_reg <= rx_full;
        scr_pkg::ADDR_USER: user_reg <= rx_full;
        scr_pkg::ADDR_SYNC: sync_reg <= rx_full;
        default: ;
      endcase
    end
  end

  // chip reset pulse held through the quiet time
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      chip_reset_o <= 1'b0;
    else
      chip_reset_o <= soft_rst || (state == SCR_ST_QUIET && quiet_cnt > 10'h001);
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sdo_o <= 1'b0;
    else
      sdo_o <= sdo_bit;
  end

  assign sdo_oe_o = !cs_n_i && state == SCR_ST_DATA && rd_wr;
  assign op_mode_o = mode_reg[1:0];
  assign power_down_o = mode_reg[1:0] == scr_pkg::SCR_MODE_POWER_DOWN;
  assign sync_ctrl_o = {sync_reg[scr_pkg::BIT_PROC_EN], sync_reg[scr_pkg::BIT_RECV_EN],
                        sync_reg[scr_pkg::BIT_ZOOM], sync_reg[3:0]};

  property soft_clear_p;
    @(posedge mclk_i) disable iff (!nrst_i) soft_rst |=> setup_reg == scr_pkg::RST_SETUP;
  endproperty
  soft_reset_clear_a: assert property (soft_clear_p) else $error("soft reset not applied");
  self_clear_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !setup_reg[scr_pkg::BIT_SOFT_RESET]) else $error("soft reset bit stuck");
  indicator_one_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    setup_reg[scr_pkg::BIT_SDO_IND]) else $error("indicator not one");
  quiet_hold_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    soft_rst |=> state == SCR_ST_QUIET [*8]) else $error("quiet time cut short");
  addr_freeze_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (state == SCR_ST_DATA && byte_done && user_reg[0] && !soft_rst) |=> $stable(addr))
    else $error("frozen address moved");
  addr_ascend_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (state == SCR_ST_DATA && byte_done && !user_reg[0] && setup_reg[5] && !soft_rst)
    |=> addr == $past(addr) + 15'h0001) else $error("address not incremented");
  addr_descend_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (state == SCR_ST_DATA && byte_done && !user_reg[0] && !setup_reg[5] && !soft_rst)
    |=> addr == $past(addr) - 15'h0001) else $error("address not decremented");
  power_down_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    power_down_o == (mode_reg[1:0] == 2'b11)) else $error("power down mismatch");
  sync_map_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    sync_ctrl_o.sync_delay_select == sync_reg[3:0] && sync_ctrl_o.sync_delay_zoom == sync_reg[4])
    else $error("sync control mismatch");
endmodule : scr_core

// File: scr_host.sv
// spi host model: drives mode 0 transfers, collects read bytes
`timescale 1ns/1ps
module scr_host (
  input wire logic mclk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // one bit: 4 mclk low, 4 mclk high
  task automatic bitx(input logic b, output logic r);
    sdi_o <= b;
    repeat (4) @(negedge mclk_i);
    r = sdo_i;
    sclk_o <= 1'b1;
    repeat (4) @(negedge mclk_i);
    sclk_o <= 1'b0;
  endtask : bitx
  task automatic xfer(input logic rd, input logic [14:0] a, input int n);
    logic [15:0] c;
    logic [7:0] d;
    logic [7:0] rb;
    logic r;
    int i;
    int k;
    c = {rd, a};
    cs_n_o <= 1'b0;
    for (k = 15; k >= 0; k--)
      bitx(c[k], r);
    for (i = 0; i < n; i++)
    begin
      d = rd ? 8'h5a : wq.pop_front();
      for (k = 7; k >= 0; k--)
      begin
        bitx(d[k], r);
        rb[k] = r;
      end
      if (rd)
        rq.push_back(rb);
    end
    repeat (4) @(negedge mclk_i);
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (4) @(negedge mclk_i);
  endtask : xfer
endmodule : scr_host

// File: scr_pkg.sv
// package: register map, field layout and timing constants for the serial config core
package scr_pkg;
  localparam logic [14:0] ADDR_SETUP = 15'h0000;
  localparam logic [14:0] ADDR_MODE = 15'h0002;
  localparam logic [14:0] ADDR_MAKER_HI = 15'h000c;
  localparam logic [14:0] ADDR_MAKER_LO = 15'h000d;
  localparam logic [14:0] ADDR_USER = 15'h0010;
  localparam logic [14:0] ADDR_SYNC = 15'h0029;
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_ASCEND = 5;
  localparam int BIT_SDO_IND = 4;
  localparam int BIT_ADDR_FREEZE = 0;
  localparam int BIT_PROC_EN = 6;
  localparam int BIT_RECV_EN = 5;
  localparam int BIT_ZOOM = 4;
  localparam logic [7:0] RST_SETUP = 8'h30;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_USER = 8'h00;
  localparam logic [7:0] RST_SYNC = 8'h80;
  localparam logic [7:0] SETUP_RO_MASK = 8'h10;
  localparam int QUIET_NS = 750;
  localparam int CLK_PERIOD_NS = 4;
  localparam int QUIET_CYCLES = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    SCR_MODE_NORMAL = 2'b00,
    SCR_MODE_RSVD1 = 2'b01,
    SCR_MODE_RSVD2 = 2'b10,
    SCR_MODE_POWER_DOWN = 2'b11
  } scr_opmode_t;
  typedef struct packed {
    logic sync_processor_enable;
    logic sync_receiver_enable;
    logic sync_delay_zoom;
    logic [3:0] sync_delay_select;
  } scr_sync_ctrl_t;
endpackage : scr_pkg

// File: scr_shift.sv
// shift engine: serial bit shifter for one byte in and one byte out
`timescale 1ns/1ps
module scr_shift (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire logic sample_i,
  input wire logic shift_i,
  input wire logic load_i,
  input wire logic [7:0] load_data_i,
  input wire logic sdi_i,
  output logic [7:0] rx_byte_o,
  output logic [2:0] bit_cnt_o,
  output logic byte_done_o,
  output logic sdo_bit_o
);
  logic [7:0] tx_sr;

  // input shifter and bit counter
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_byte_o <= 8'h00;
      bit_cnt_o <= 3'h0;
    end
    else if (clr_i)
    begin
      bit_cnt_o <= 3'h0;
    end
    else if (sample_i)
    begin
      rx_byte_o <= {rx_byte_o[6:0], sdi_i};
      bit_cnt_o <= bit_cnt_o + 3'h1;
    end
  end

  assign byte_done_o = sample_i && (bit_cnt_o == 3'h7) && !clr_i;

  // output shifter, msb first
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tx_sr <= 8'h00;
    end
    else if (load_i)
    begin
      tx_sr <= load_data_i;
    end
    else if (shift_i)
    begin
      tx_sr <= {tx_sr[6:0], 1'b0};
    end
  end

  assign sdo_bit_o = tx_sr[7];
endmodule : scr_shift

// File: test_scr_core.sv
// testbench: scr_core against a register model
`timescale 1ns/1ps
module test_scr_core;
  localparam logic [15:0] MK = 16'h5a3c; // arbitrary value
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic sclk, cs_n, sdi, sdo, sdo_oe, crst, pd;
  logic [1:0] opm;
  scr_pkg::scr_sync_ctrl_t syc;
  int num_errors = 0;
  int n_compared = 0;
  int oe_cnt = 0;
  logic [31:0] seed = 32'h0000_8dca;
  logic [7:0] m_setup, m_mode, m_user, m_sync, d;
  logic [7:0] wq[$];
  int i;
  always #2 mclk_i = ~mclk_i;
  // counts cycles with the read driver enabled
  always @(posedge mclk_i)
  begin
    if (sdo_oe === 1'b1)
      oe_cnt++;
  end
  scr_core #(.MAKER_CODE(MK)) uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .chip_reset_o(crst),
    .power_down_o(pd), .op_mode_o(opm), .sync_ctrl_o(syc));
  scr_host host (.mclk_i(mclk_i), .sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic void mreset();
    m_setup = 8'h30;
    m_mode = 8'h00;
    m_user = 8'h00;
    m_sync = 8'h80;
  endfunction : mreset
  function automatic logic [7:0] mrd(input logic [14:0] a);
    case (a)
      15'h0000: return m_setup;
      15'h0002: return m_mode;
      15'h000c: return MK[15:8];
      15'h000d: return MK[7:0];
      15'h0010: return m_user;
      15'h0029: return m_sync;
      default: return 8'h00;
    endcase
  endfunction : mrd
  function automatic void mwr(input logic [14:0] a, input logic [7:0] v);
    case (a)
      15'h0000: if (v[7]) mreset(); else m_setup = (v & 8'h6f) | 8'h10;
      15'h0002: m_mode = v;
      15'h0010: m_user = v;
      15'h0029: m_sync = v;
      default: ;
    endcase
  endfunction : mwr
  task automatic txn(input logic rd, input logic [14:0] a, input int n);
    logic [14:0] p;
    int k;
    int oe0;
    p = a;
    host.wq = wq;
    oe0 = oe_cnt;
    host.xfer(rd, a, n);
    chk("sdo_oe", {7'h00, rd}, {7'h00, oe_cnt != oe0});
    for (k = 0; k < n; k++)
    begin
      if (rd)
        chk("rd_data", mrd(p), host.rq.pop_front());
      else
        mwr(p, wq[k]);
      p = m_user[0] ? p : (m_setup[5] ? p + 15'h0001 : p - 15'h0001);
    end
    wq = {};
    chk("op_mode", {6'h00, m_mode[1:0]}, {6'h00, opm});
    chk("power_down", {7'h00, m_mode[1:0] == 2'b11}, {7'h00, pd});
    chk("sync_ctrl", {1'b0, m_sync[6:0]}, {1'b0, syc});
  endtask : txn
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (60000) @(posedge mclk_i);
    num_errors++;
    $display("[ERR] run expected end seen hang");
    summarize();
  end
  initial
  begin
    mreset();
    repeat (5) @(negedge mclk_i);
    nrst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    txn(1'b1, 15'h0000, 1);
    txn(1'b1, 15'h0002, 1);
    txn(1'b1, 15'h0010, 1);
    txn(1'b1, 15'h0029, 1);
    txn(1'b1, 15'h0005, 1);
    txn(1'b1, 15'h000c, 2);
    $display("test reset_values done");
    for (i = 0; i < 4; i++)
    begin
      wq.push_back(i[7:0]);
      txn(1'b0, 15'h0002, 1);
      txn(1'b1, 15'h0002, 1);
    end
    $display("test op_mode done");
    repeat (4)
    begin
      d = rnd();
      wq.push_back(d & 8'hbf);
      txn(1'b0, 15'h0029, 1);
      wq.push_back(d | 8'h20);
      txn(1'b0, 15'h0029, 1);
      txn(1'b1, 15'h0029, 1);
    end
    $display("test sync_ctrl done");
    repeat (3)
    begin
      wq.push_back(rnd() & 8'h7f);
      txn(1'b0, 15'h0000, 1);
      txn(1'b1, 15'h0000, 1);
      txn(1'b1, 15'h000d, 2);
    end
    wq.push_back(8'h00);
    txn(1'b0, 15'h0000, 1);
    txn(1'b1, 15'h000d, 2);
    wq.push_back(8'h20);
    txn(1'b0, 15'h0000, 1);
    $display("test stream_dir done");
    wq = {8'h01};
    txn(1'b0, 15'h0010, 1);
    wq = {8'h01, 8'h02, 8'h03};
    txn(1'b0, 15'h0002, 3);
    txn(1'b1, 15'h0002, 3);
    wq = {8'h00};
    txn(1'b0, 15'h0010, 1);
    wq = {8'hff, 8'hff};
    txn(1'b0, 15'h000c, 2);
    txn(1'b1, 15'h000c, 2);
    $display("test freeze_maker done");
    wq = {8'h80};
    txn(1'b0, 15'h0000, 1);
    chk("chip_reset", 8'h01, {7'h00, crst});
    repeat (scr_pkg::QUIET_CYCLES) @(negedge mclk_i);
    chk("chip_reset", 8'h00, {7'h00, crst});
    txn(1'b1, 15'h0000, 1);
    txn(1'b1, 15'h0029, 1);
    txn(1'b1, 15'h0002, 1);
    $display("test soft_reset done");
    summarize();
  end
endmodule : test_scr_core
